// >>> hdl/cpfm_monitor.sv
// Critical pin fault monitor: gate-control pin and programming pin checks
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE1: After supply turn-on, regulate the gate-control pin toward 11 V before pulsing.
// RULE2: Ten microseconds after turn-on, gate-control below 12 V forces one restart, no pulses.
// RULE3: While switching, compare gate-control pin against 13.8 V every cycle.
// RULE4: Overvoltage on three consecutive gate pulses stops switching and forces one restart.
// RULE5: After turn-on, bias each timing pin and measure its outgoing current.
// RULE6: Current below range means open pin; above range means shorted pin.
// RULE7: Open or shorted timing pin causes exactly one restart cycle.
// RULE8: A gate pulse ending without overvoltage clears the consecutive count.
module cpfm_monitor
  import cpfm_pkg::*;
#(
  parameter int unsigned CHECK_CYC   = HVG_CHECK_CYC,
  parameter int unsigned RESTART_CYC = RESTART_HOLD_CYC,
  parameter int unsigned OV_LIMIT    = OV_PULSE_LIMIT
)
(
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             supply_on,
  input  wire cpfm_gate_sense_s gate_sense,
  input  wire logic             low_side_gate_pulse,
  input  wire cpfm_prog_sense_s magnetizing_sense,
  input  wire cpfm_prog_sense_s transition_sense,
  output logic                  gate_ctl_reg_en_q,
  output logic                  prog_bias_en_q,
  output logic                  switch_enable_q,
  output logic                  restart_q,
  output logic [CAUSE_W-1:0]    fault_cause_q
);

  // ****************************************
  // State and counters
  // ****************************************
  cpfm_state_e state_q;
  logic [15:0] tmr_q;
  logic [1:0]  ov_cnt_q;
  logic        pulse_q;
  logic        ov_seen_q;
  logic        check_now;
  logic        pulse_end;
  logic        mag_open;
  logic        mag_short;
  logic        trz_open;
  logic        trz_short;
  logic        prog_fault;
  logic        hvg_low_fault;
  logic        ov_fault;

  assign check_now     = (state_q == ST_SETTLE) && (tmr_q == 16'(CHECK_CYC - 1));
  assign pulse_end     = pulse_q && !low_side_gate_pulse;
  assign prog_fault    = mag_open | mag_short | trz_open | trz_short;
  // RULE2 startup low check
  assign hvg_low_fault = check_now && gate_sense.gate_ctl_below_12v;
  // RULE4 three consecutive overvoltage
  assign ov_fault      = pulse_end && ov_seen_q && (ov_cnt_q == 2'(OV_LIMIT - 1));

  // ****************************************
  // Programming pin classifiers
  // ****************************************
  // RULE5 sample pin currents
  cpfm_prog_check u_mag
  (
    .clk     (clk),
    .resetn  (resetn),
    .sample  (check_now),
    .sense   (magnetizing_sense),
    .open_q  (mag_open),
    .short_q (mag_short)
  );

  cpfm_prog_check u_trz
  (
    .clk     (clk),
    .resetn  (resetn),
    .sample  (check_now),
    .sense   (transition_sense),
    .open_q  (trz_open),
    .short_q (trz_short)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ST_OFF;
      tmr_q   <= 16'h0000;
    end
    else
    begin
      case (state_q)
        ST_OFF:
        begin
          tmr_q <= 16'h0000;
          if (supply_on)
            state_q <= ST_SETTLE;
        end
        ST_SETTLE:
        begin
          tmr_q <= tmr_q + 16'h0001;
          if (hvg_low_fault)
          begin
            state_q <= ST_RESTART;
            tmr_q   <= 16'h0000;
          end
          else if (check_now)
            state_q <= ST_RUN;
        end
        ST_RUN:
        begin
          // RULE7 one restart per fault
          if (prog_fault || ov_fault)
          begin
            state_q <= ST_RESTART;
            tmr_q   <= 16'h0000;
          end
        end
        ST_RESTART:
        begin
          tmr_q <= tmr_q + 16'h0001;
          if (tmr_q == 16'(RESTART_CYC - 1))
            state_q <= ST_OFF;
        end
        default:
          state_q <= ST_OFF;
      endcase
    end
  end

  // ****************************************
  // Overvoltage counting per pulse
  // ****************************************
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pulse_q   <= 1'b0;
      ov_seen_q <= 1'b0;
      ov_cnt_q  <= 2'h0;
    end
    else
    begin
      pulse_q <= low_side_gate_pulse;
      if (state_q != ST_RUN)
      begin
        ov_seen_q <= 1'b0;
        ov_cnt_q  <= 2'h0;
      end
      else
      begin
        // RULE3 compare each cycle
        if (low_side_gate_pulse && gate_sense.gate_ctl_above_ov)
          ov_seen_q <= 1'b1;
        else if (pulse_end)
          ov_seen_q <= 1'b0;
        if (pulse_end)
        begin
          // RULE8 clean pulse clears
          if (!ov_seen_q)
            ov_cnt_q <= 2'h0;
          else if (ov_cnt_q != 2'(OV_LIMIT - 1))
            ov_cnt_q <= ov_cnt_q + 2'h1;
        end
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gate_ctl_reg_en_q <= 1'b0;
      prog_bias_en_q    <= 1'b0;
      switch_enable_q   <= 1'b0;
      restart_q         <= 1'b0;
    end
    else
    begin
      // RULE1 regulate before pulses
      gate_ctl_reg_en_q <= (state_q == ST_SETTLE) || (state_q == ST_RUN);
      prog_bias_en_q    <= (state_q == ST_SETTLE);
      switch_enable_q   <= (state_q == ST_RUN) && !prog_fault && !ov_fault;
      restart_q         <= (state_q == ST_RESTART);
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      fault_cause_q <= CAUSE_RESET;
    else if (state_q == ST_OFF && supply_on)
      fault_cause_q <= CAUSE_RESET;
    else
    begin
      if (hvg_low_fault)
        fault_cause_q[CAUSE_HVG_LOW] <= 1'b1;
      if (ov_fault && state_q == ST_RUN)
        fault_cause_q[CAUSE_HVG_OV] <= 1'b1;
      if ((mag_open || trz_open) && state_q == ST_RUN)
        fault_cause_q[CAUSE_PROG_OPEN] <= 1'b1;
      if ((mag_short || trz_short) && state_q == ST_RUN)
        fault_cause_q[CAUSE_PROG_SHORT] <= 1'b1;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_no_early_switch: assert property (@(posedge clk) disable iff (!resetn) // RULE1
    switch_enable_q |-> gate_ctl_reg_en_q)
    else $error("Switching without gate-control regulation");
  a_low_restart: assert property (@(posedge clk) disable iff (!resetn) // RULE2
    hvg_low_fault |=> ##1 (restart_q && !switch_enable_q))
    else $error("Low gate-control pin did not force restart");
  a_ov_count: assert property (@(posedge clk) disable iff (!resetn) // RULE3
    (state_q == ST_RUN && pulse_end && ov_seen_q && ov_cnt_q == 2'h0) |=> ov_cnt_q == 2'h1)
    else $error("Overvoltage pulse not counted");
  a_ov_restart: assert property (@(posedge clk) disable iff (!resetn) // RULE4
    (state_q == ST_RUN && ov_fault) |=> !switch_enable_q ##1 restart_q)
    else $error("Third overvoltage pulse did not restart");
  a_bias_check: assert property (@(posedge clk) disable iff (!resetn) // RULE5
    check_now |-> prog_bias_en_q)
    else $error("Pin current sampled without bias");
  a_prog_restart: assert property (@(posedge clk) disable iff (!resetn) // RULE7
    (state_q == ST_RUN && prog_fault) |=> ##1 restart_q)
    else $error("Programming pin fault did not restart");
  a_single_restart: assert property (@(posedge clk) disable iff (!resetn) // RULE7
    $fell(restart_q) |-> !restart_q [*2])
    else $error("Restart repeated without new start-up");
  a_clean_clear: assert property (@(posedge clk) disable iff (!resetn) // RULE8
    (state_q == ST_RUN && pulse_end && !ov_seen_q) |=> ov_cnt_q == 2'h0)
    else $error("Clean pulse did not clear count");

  c_run: cover property (@(posedge clk) disable iff (!resetn) switch_enable_q);
  c_low: cover property (@(posedge clk) disable iff (!resetn) hvg_low_fault);
  c_ov: cover property (@(posedge clk) disable iff (!resetn) ov_fault && state_q == ST_RUN);
  c_prog: cover property (@(posedge clk) disable iff (!resetn) prog_fault && state_q == ST_RUN);

endmodule
`default_nettype wire

// >>> inc/cpfm_pkg.sv
// Package of constants and carrier types for the critical pin fault monitor
`default_nettype none
package cpfm_pkg;

  // Clock rate and timing
  localparam int unsigned CLK_FREQ_MHZ     = 125;
  localparam int unsigned HVG_CHECK_DLY_US = 10;
  localparam int unsigned HVG_CHECK_CYC    = HVG_CHECK_DLY_US * CLK_FREQ_MHZ;
  localparam int unsigned RESTART_HOLD_US  = 20;
  localparam int unsigned RESTART_HOLD_CYC = RESTART_HOLD_US * CLK_FREQ_MHZ;

  // Fault counting
  localparam int unsigned OV_PULSE_LIMIT   = 3;

  // Fault cause field positions
  localparam int unsigned CAUSE_HVG_LOW    = 0;
  localparam int unsigned CAUSE_HVG_OV     = 1;
  localparam int unsigned CAUSE_PROG_OPEN  = 2;
  localparam int unsigned CAUSE_PROG_SHORT = 3;
  localparam int unsigned CAUSE_W          = 4;
  localparam logic [3:0]  CAUSE_RESET      = 4'h0;

  // Comparator results from the analog front end
  typedef struct packed {
    logic gate_ctl_below_12v;
    logic gate_ctl_above_ov;
  } cpfm_gate_sense_s;

  // Current window result for one timing-programming pin
  typedef struct packed {
    logic cur_below_range;
    logic cur_above_range;
  } cpfm_prog_sense_s;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_SETTLE,
    ST_RUN,
    ST_RESTART
  } cpfm_state_e;

endpackage
`default_nettype wire

// >>> hdl/cpfm_prog_check.sv
// Open/short classifier for one timing-programming pin
`timescale 1ns/1ps
`default_nettype none
module cpfm_prog_check
  import cpfm_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             sample,
  input  wire cpfm_prog_sense_s sense,
  output logic                  open_q,
  output logic                  short_q
);

  // RULE6 classify open short
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      open_q  <= 1'b0;
      short_q <= 1'b0;
    end
    else if (sample)
    begin
      open_q  <= sense.cur_below_range;
      short_q <= sense.cur_above_range;
    end
    else
    begin
      open_q  <= 1'b0;
      short_q <= 1'b0;
    end
  end

  a_open_class: assert property (@(posedge clk) disable iff (!resetn) // RULE6
    sample && sense.cur_below_range |=> open_q)
    else $error("Low pin current not classed as open");
  a_short_class: assert property (@(posedge clk) disable iff (!resetn) // RULE6
    sample && sense.cur_above_range |=> short_q)
    else $error("High pin current not classed as short");

endmodule
`default_nettype wire

// >>> sim/cpfm_plant.sv
// Behavioural model of the external gate-control and programming-pin network
`timescale 1ns/1ps
`default_nettype none
module cpfm_plant
  import cpfm_pkg::*;
(
  input  wire logic             reg_en,
  input  wire logic             bias_en,
  input  wire logic             pulse,
  input  wire logic             hvg_open,
  input  wire logic             ov_mode,
  input  wire cpfm_prog_sense_s mag_code,
  input  wire cpfm_prog_sense_s tr_code,
  output wire cpfm_gate_sense_s gate_sense,
  output wire cpfm_prog_sense_s mag_sense,
  output wire cpfm_prog_sense_s tr_sense
);
  // Open pin settles fast to 11 V; a fitted capacitor stays above 12 V
  assign gate_sense.gate_ctl_below_12v = hvg_open & reg_en;
  // Overshoot only appears while a pulse switches the node
  assign gate_sense.gate_ctl_above_ov  = ov_mode & pulse;
  // Unbiased pins carry no current
  assign mag_sense = bias_en ? mag_code : 2'h2;
  assign tr_sense  = bias_en ? tr_code : 2'h2;
endmodule
`default_nettype wire

// >>> sim/cpfm_monitor_tb_top.sv
// Self-checking testbench for the critical pin fault monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module cpfm_monitor_tb_top
  import cpfm_pkg::*;
;
  localparam int unsigned RS = 16;
  logic               clk        = 1'b0;
  logic               resetn     = 1'b0;
  logic               supply_on  = 1'b0;
  logic               pulse      = 1'b0;
  logic               hvg_open   = 1'b0;
  logic               ov_mode    = 1'b0;
  cpfm_prog_sense_s   mag_code   = 2'h0;
  cpfm_prog_sense_s   tr_code    = 2'h0;
  cpfm_gate_sense_s   gate_sense;
  cpfm_prog_sense_s   mag_sense;
  cpfm_prog_sense_s   tr_sense;
  logic               reg_en;
  logic               bias_en;
  logic               sw_en;
  logic               restart;
  logic [CAUSE_W-1:0] cause;
  int                 n_fail     = 0;
  int                 n_compared = 0;

  always #4 clk = ~clk;

  cpfm_monitor #(.CHECK_CYC(8), .RESTART_CYC(RS), .OV_LIMIT(3)) cpfm_monitor_inst (
    .clk(clk), .resetn(resetn), .supply_on(supply_on), .gate_sense(gate_sense),
    .low_side_gate_pulse(pulse), .magnetizing_sense(mag_sense), .transition_sense(tr_sense),
    .gate_ctl_reg_en_q(reg_en), .prog_bias_en_q(bias_en), .switch_enable_q(sw_en),
    .restart_q(restart), .fault_cause_q(cause));

  cpfm_plant cpfm_plant_inst (
    .reg_en(reg_en), .bias_en(bias_en), .pulse(pulse), .hvg_open(hvg_open),
    .ov_mode(ov_mode), .mag_code(mag_code), .tr_code(tr_code),
    .gate_sense(gate_sense), .mag_sense(mag_sense), .tr_sense(tr_sense));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic complete_run();
    $display("Counts: compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic power_up(input logic hv, input cpfm_prog_sense_s m, input cpfm_prog_sense_s t);
    @(negedge clk);
    resetn = 1'b0;
    supply_on = 1'b0;
    hvg_open = hv;
    mag_code = m;
    tr_code = t;
    ov_mode = 1'b0;
    @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    supply_on = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(reg_en, 1'b1)
    `CHK(bias_en, 1'b1)
    `CHK(sw_en, 1'b0)
    for (int i = 0; i < 40 && sw_en !== 1'b1 && restart !== 1'b1; i++)
      @(negedge clk);
  endtask

  task automatic gate_pulse(input logic ov);
    ov_mode = ov;
    pulse = 1'b1;
    repeat (2) @(negedge clk);
    pulse = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic t_clean();
    power_up(1'b0, 2'h0, 2'h0);
    repeat (4) gate_pulse(1'b0);
    `CHK(sw_en, 1'b1)
    `CHK(restart, 1'b0)
    `CHK(cause, 4'h0)
    $display("test clean done");
  endtask

  task automatic t_hvg();
    power_up(1'b1, 2'h0, 2'h0);
    `CHK(restart, 1'b1)
    `CHK(sw_en, 1'b0)
    `CHK(cause, 4'h1)
    $display("test gate-control low done");
  endtask

  task automatic t_ov();
    power_up(1'b0, 2'h0, 2'h0);
    repeat (2) gate_pulse(1'b1);
    gate_pulse(1'b0);
    repeat (2) gate_pulse(1'b1);
    `CHK(restart, 1'b0)
    `CHK(sw_en, 1'b1)
    gate_pulse(1'b1);
    repeat (2) @(negedge clk);
    `CHK(restart, 1'b1)
    `CHK(sw_en, 1'b0)
    `CHK(cause, 4'h2)
    $display("test overvoltage done");
  endtask

  task automatic t_prog();
    cpfm_prog_sense_s c;
    int               n;
    for (int k = 0; k < 4; k++)
    begin
      c = k[0] ? 2'h1 : 2'h2;
      power_up(1'b0, k < 2 ? c : 2'h0, k < 2 ? 2'h0 : c);
      `CHK(restart, 1'b1)
      `CHK(cause, k[0] ? 4'h8 : 4'h4)
      supply_on = 1'b0;
      n = 0;
      while (restart === 1'b1 && n < RS + 4)
      begin
        @(negedge clk);
        n++;
      end
      `CHK(n, RS)
      repeat (4) @(negedge clk);
      `CHK(restart, 1'b0)
      `CHK(sw_en, 1'b0)
    end
    $display("test programming pins done");
  endtask

  initial
  begin
    #20000;
    n_fail++;
    complete_run();
  end

  initial
  begin
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    t_clean();
    t_hvg();
    t_ov();
    t_prog();
    complete_run();
  end
endmodule
`default_nettype wire
